// *** e1w_pkg.sv ***
package e1w_pkg;

  // ==========================================================
  // Setting word layout
  // ==========================================================
  localparam int CFG_W          = 32;
  localparam int POS_ACTIVE     = 0;
  localparam int POS_MODE       = 1;   // 2 bits
  localparam int POS_FRAME      = 3;
  localparam int POS_TS16       = 4;   // 2 bits
  localparam int POS_EVEN_INV   = 6;
  localparam int POS_KEEP_ALIVE = 7;
  localparam int POS_LINE_LB    = 8;
  localparam int POS_LOCAL_LB   = 9;
  localparam int POS_CH_LB      = 10;
  localparam int POS_LOOP_SEL   = 11;  // 5 bits
  localparam int POS_LOOP_GEN   = 16;  // 2 bits
  localparam int POS_MGMT       = 18;  // 2 bits
  localparam int POS_THRESH     = 20;  // 3 bits
  localparam int POS_FAILOVER   = 23;  // 2 bits
  localparam int POS_GROUP      = 25;  // 3 bits

  // Defaults: standby, xcon, crc, nos, norm, none, off, slot 1, 10e-1.
  localparam logic [CFG_W-1:0] CFG_RESET = 32'h0010_0824;

  localparam logic [1:0] MODE_TERM = 2'h0;
  localparam logic [1:0] MODE_DI   = 2'h1;
  localparam logic [1:0] MODE_XCON = 2'h2;
  localparam logic [1:0] TS16_CAS  = 2'h0;
  localparam logic [1:0] TS16_CCS  = 2'h1;
  localparam logic [1:0] TS16_NOS  = 2'h2;
  localparam logic [1:0] GEN_OFF   = 2'h0;
  localparam logic [1:0] GEN_LLB   = 2'h1;
  localparam logic [1:0] GEN_PLB   = 2'h2;
  localparam logic [1:0] GEN_NLB   = 2'h3;
  localparam logic [1:0] MGMT_NONE = 2'h0;
  localparam logic [1:0] MGMT_SA4  = 2'h1;
  localparam logic [1:0] MGMT_TS31 = 2'h2;
  localparam logic [2:0] THR_NONE  = 3'h0;
  localparam logic [1:0] FO_NONE   = 2'h0;
  localparam logic [1:0] FO_OUT_OF_SERVICE = 2'h1;
  localparam logic [1:0] FO_CARRIER_ALARM  = 2'h2;

  localparam logic [4:0] TS_SIG    = 5'h10;
  localparam logic [4:0] TS_MGMT   = 5'h1F;
  localparam logic [7:0] AIS_BYTE  = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hD5;
  localparam logic [7:0] EVEN_MASK = 8'h55;
  localparam logic [7:0] CODE_LLB  = 8'h2A;
  localparam logic [7:0] CODE_PLB  = 8'h2C;
  localparam logic [7:0] CODE_NLB  = 8'h2E;

  typedef enum logic [1:0] {
    E1W_RUN  = 2'b00,
    E1W_LOOP = 2'b01,
    E1W_STBY = 2'b10
  } e1w_state_type;

endpackage

// *** e1w_cfg_store.sv ***
`timescale 1ns/1ps
// Staged and saved copies of one port's settings.
module e1w_cfg_store
  import e1w_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             stage_we_i,
  input  wire logic [CFG_W-1:0] stage_data_i,
  input  wire logic             save_i,
  input  wire logic             undo_i,
  output logic      [CFG_W-1:0] saved_o,
  output logic      [CFG_W-1:0] staged_o
);
  logic [CFG_W-1:0] next_saved;
  logic [CFG_W-1:0] next_staged;

  always_comb begin
    next_saved  = saved_o;
    next_staged = staged_o;
    if (save_i) begin
      next_saved = staged_o;
    end else if (undo_i) begin
      next_staged = saved_o;
    end else if (stage_we_i) begin
      next_staged = stage_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      saved_o  <= CFG_RESET;
      staged_o <= CFG_RESET;
    end else begin
      saved_o  <= next_saved;
      staged_o <= next_staged;
    end
  end
endmodule

// *** e1w_port.sv ***
`timescale 1ns/1ps
// One E1 port: byte-serial timeslot stream on both faces.
module e1w_port
  import e1w_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             stage_we_i,
  input  wire logic [CFG_W-1:0] stage_data_i,
  input  wire logic             save_i,
  input  wire logic             undo_i,
  input  wire logic             slot_strobe_i,
  input  wire logic [4:0]       slot_num_i,
  input  wire logic [7:0]       line_rx_i,
  input  wire logic [7:0]       mate_rx_i,
  input  wire logic [7:0]       pcm_tx_i,
  input  wire logic             pcm_tx_valid_i,
  input  wire logic [7:0]       mgmt_tx_i,
  input  wire logic             link_fail_i,
  input  wire logic             mate_link_fail_i,
  input  wire logic [2:0]       upstream_fail_group_i,
  input  wire logic             upstream_fail_i,
  input  wire logic [2:0]       error_rate_exp_i,
  input  wire logic             out_of_service_i,
  input  wire logic             carrier_alarm_i,
  output logic      [7:0]       line_tx_o,
  output logic      [7:0]       pcm_rx_o,
  output logic                  pcm_rx_valid_o,
  output logic      [7:0]       mate_tx_o,
  output logic      [7:0]       mgmt_rx_o,
  output logic                  mgmt_rx_valid_o,
  output logic                  mgmt_spare_bit_o,
  output logic                  crc4_enable_o,
  output logic                  sig_slot_o,
  output logic                  error_alarm_o,
  output logic                  failover_o,
  output logic                  group_fail_o,
  output logic      [CFG_W-1:0] cfg_readback_o,
  output logic      [1:0]       port_state_o
);
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] staged;

  e1w_cfg_store u_store (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .stage_we_i   (stage_we_i),
    .stage_data_i (stage_data_i),
    .save_i       (save_i),
    .undo_i       (undo_i),
    .saved_o      (cfg),
    .staged_o     (staged)
  );

  // ==========================================================
  // Field decode of the saved settings
  // ==========================================================
  logic       f_active;
  logic [1:0] f_mode;
  logic       f_dframe;
  logic [1:0] f_ts16;
  logic       f_even;
  logic       f_keep;
  logic       f_line_lb;
  logic       f_local_lb;
  logic       f_ch_lb;
  logic [4:0] channel_loop_select;
  logic [1:0] loop_code_generator;
  logic [1:0] mgmt_channel_select;
  logic [2:0] error_alarm_threshold;
  logic [1:0] failover_trigger;
  logic [2:0] f_group;

  assign f_active              = cfg[POS_ACTIVE];
  assign f_mode                = cfg[POS_MODE +: 2];
  assign f_dframe              = cfg[POS_FRAME];
  assign f_ts16                = cfg[POS_TS16 +: 2];
  assign f_even                = cfg[POS_EVEN_INV];
  assign f_keep                = cfg[POS_KEEP_ALIVE];
  assign f_line_lb             = cfg[POS_LINE_LB];
  assign f_local_lb            = cfg[POS_LOCAL_LB];
  assign f_ch_lb               = cfg[POS_CH_LB];
  assign channel_loop_select   = cfg[POS_LOOP_SEL +: 5];
  assign loop_code_generator   = cfg[POS_LOOP_GEN +: 2];
  assign mgmt_channel_select   = cfg[POS_MGMT +: 2];
  assign error_alarm_threshold = cfg[POS_THRESH +: 3];
  assign failover_trigger      = cfg[POS_FAILOVER +: 2];
  assign f_group               = cfg[POS_GROUP +: 3];

  // ==========================================================
  // Port state
  // ==========================================================
  e1w_state_type next_state;

  always_comb begin
    if (!f_active) begin
      next_state = E1W_STBY;
    end else if (f_line_lb || f_local_lb) begin
      next_state = E1W_LOOP;
    end else begin
      next_state = E1W_RUN;
    end
  end

  // ==========================================================
  // Timeslot datapath
  // ==========================================================
  logic       is_sig;
  logic       is_mgmt;
  logic       grp_fail;
  logic       ais_out;
  logic [7:0] rx_byte;
  logic [7:0] tx_user;
  logic [7:0] next_line_tx;
  logic [7:0] next_pcm_rx;
  logic       next_pcm_valid;
  logic [7:0] next_mate_tx;
  logic [7:0] next_mgmt_rx;
  logic       next_mgmt_valid;
  logic       next_spare;
  logic       next_alarm;
  logic       next_failover;

  always_comb begin
    // Slot 16 is signalling unless nos frees it for user data.
    is_sig  = (f_ts16 != TS16_NOS) && (slot_num_i == TS_SIG);
    is_mgmt = (mgmt_channel_select == MGMT_TS31)
              && (slot_num_i == TS_MGMT);
    grp_fail = (f_group != 3'h0) && upstream_fail_i
               && (upstream_fail_group_i == f_group);
    ais_out  = (f_keep && mate_link_fail_i) || grp_fail;
    rx_byte  = f_even ? (line_rx_i ^ EVEN_MASK) : line_rx_i;
    tx_user  = f_even ? (pcm_tx_i ^ EVEN_MASK) : pcm_tx_i;

    next_line_tx    = tx_user;
    next_pcm_rx     = rx_byte;
    next_pcm_valid  = 1'b0;
    next_mate_tx    = IDLE_BYTE;
    next_mgmt_rx    = mgmt_rx_o;
    next_mgmt_valid = 1'b0;
    next_spare      = mgmt_spare_bit_o;

    if (slot_strobe_i) begin
      next_pcm_valid = !is_sig && !is_mgmt;
      if (f_mode == MODE_TERM) begin
        // Unclaimed slots stay idle; never bridged to the mate link.
        next_line_tx = pcm_tx_valid_i ? tx_user : IDLE_BYTE;
      end else if (pcm_tx_valid_i) begin
        next_line_tx = tx_user;
      end else begin
        next_line_tx   = mate_rx_i;
        next_mate_tx   = line_rx_i;
        next_pcm_valid = 1'b0;
      end
      // This link is down, so the mate link is kept alive with AIS.
      if (f_keep && link_fail_i) begin
        next_mate_tx = AIS_BYTE;
      end
      if (is_mgmt) begin
        next_line_tx    = mgmt_tx_i;
        next_mgmt_rx    = line_rx_i;
        next_mgmt_valid = 1'b1;
      end
      if (mgmt_channel_select == MGMT_SA4) begin
        next_spare = mgmt_tx_i[0];
      end
      if (loop_code_generator != GEN_OFF) begin
        unique case (loop_code_generator)
          GEN_LLB: next_line_tx = CODE_LLB;
          GEN_PLB: next_line_tx = CODE_PLB;
          default: next_line_tx = CODE_NLB;
        endcase
      end
      if (ais_out) begin
        next_line_tx = AIS_BYTE;
      end
      if (f_ch_lb && slot_num_i == channel_loop_select) begin
        next_pcm_rx    = pcm_tx_i;
        next_pcm_valid = 1'b1;
      end
      if (f_local_lb) begin
        next_pcm_rx    = pcm_tx_i;
        next_pcm_valid = 1'b1;
        next_line_tx   = AIS_BYTE;
      end
      if (f_line_lb) begin
        next_line_tx = line_rx_i;
      end
    end
    if (next_state == E1W_STBY) begin
      next_line_tx    = IDLE_BYTE;
      next_pcm_valid  = 1'b0;
      next_mate_tx    = IDLE_BYTE;
      next_mgmt_valid = 1'b0;
    end

    // Larger exponent means a stricter (lower) error rate.
    next_alarm = (error_alarm_threshold != THR_NONE)
                 && (error_rate_exp_i != 3'h0)
                 && (error_rate_exp_i <= error_alarm_threshold);
    unique case (failover_trigger)
      FO_OUT_OF_SERVICE: next_failover = out_of_service_i;
      FO_CARRIER_ALARM:  next_failover = carrier_alarm_i;
      default: next_failover = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      line_tx_o        <= IDLE_BYTE;
      pcm_rx_o         <= 8'h00;
      pcm_rx_valid_o   <= 1'b0;
      mate_tx_o        <= IDLE_BYTE;
      mgmt_rx_o        <= 8'h00;
      mgmt_rx_valid_o  <= 1'b0;
      mgmt_spare_bit_o <= 1'b1;
      crc4_enable_o    <= 1'b1;
      sig_slot_o       <= 1'b0;
      error_alarm_o    <= 1'b0;
      failover_o       <= 1'b0;
      group_fail_o     <= 1'b0;
      cfg_readback_o   <= CFG_RESET;
      port_state_o     <= 2'h2;
    end else begin
      line_tx_o        <= next_line_tx;
      pcm_rx_o         <= next_pcm_rx;
      pcm_rx_valid_o   <= next_pcm_valid;
      mate_tx_o        <= next_mate_tx;
      mgmt_rx_o        <= next_mgmt_rx;
      mgmt_rx_valid_o  <= next_mgmt_valid;
      mgmt_spare_bit_o <= next_spare;
      crc4_enable_o    <= !f_dframe;
      sig_slot_o       <= slot_strobe_i && is_sig;
      error_alarm_o    <= next_alarm;
      failover_o       <= next_failover && f_active;
      // A port in no group propagates nothing, not even its own fail.
      group_fail_o     <= grp_fail
                          || (link_fail_i && f_group != 3'h0);
      cfg_readback_o   <= staged;
      port_state_o     <= next_state;
    end
  end
endmodule

// *** e1w_chk.sv ***
`timescale 1ns/1ps
module e1w_chk
  import e1w_pkg::*;
(
  input wire logic             sys_clk_i,
  input wire logic             reset_i,
  input wire logic             stage_we_i,
  input wire logic             save_i,
  input wire logic             undo_i,
  input wire logic             slot_strobe_i,
  input wire logic [4:0]       slot_num_i,
  input wire logic [2:0]       error_rate_exp_i,
  input wire logic             out_of_service_i,
  input wire logic             carrier_alarm_i,
  input wire logic             upstream_fail_i,
  input wire logic             link_fail_i,
  input wire logic             pcm_rx_valid_o,
  input wire logic             mgmt_rx_valid_o,
  input wire logic             sig_slot_o,
  input wire logic             crc4_enable_o,
  input wire logic             error_alarm_o,
  input wire logic             failover_o,
  input wire logic             group_fail_o,
  input wire logic [CFG_W-1:0] cfg_readback_o,
  input wire logic [1:0]       port_state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ======================================
  // Port checks
  AST_RESET_DEFAULT: assert property (
    $fell(reset_i) |-> port_state_o == E1W_STBY
      && cfg_readback_o == CFG_RESET && crc4_enable_o)
    else $error("settings not at defaults after reset");
  AST_STATE_ON_SAVE: assert property (
    $changed(port_state_o) |->
      $past(save_i) || $past(save_i, 2) || $past(save_i, 3))
    else $error("port state moved without a save");
  AST_FRAME_ON_SAVE: assert property (
    $changed(crc4_enable_o) |->
      $past(save_i) || $past(save_i, 2) || $past(save_i, 3))
    else $error("frame format moved without a save");
  AST_STAGED_COPY: assert property (
    $changed(cfg_readback_o) |-> $past(stage_we_i)
      || $past(undo_i) || $past(stage_we_i, 2) || $past(undo_i, 2))
    else $error("staged copy moved without stage or undo");
  AST_PCM_VALID: assert property (
    pcm_rx_valid_o |-> $past(slot_strobe_i))
    else $error("pcm valid without a timeslot");
  AST_SIG_SLOT: assert property (
    sig_slot_o |-> $past(slot_strobe_i) && $past(slot_num_i) == TS_SIG)
    else $error("signalling flag outside timeslot 16");
  AST_MGMT_SLOT: assert property (
    mgmt_rx_valid_o |->
      $past(slot_strobe_i) && $past(slot_num_i) == TS_MGMT)
    else $error("management byte outside timeslot 31");
  AST_ALARM_CAUSE: assert property (
    error_alarm_o |-> $past(error_rate_exp_i) != 3'h0
      || $past(error_rate_exp_i, 2) != 3'h0)
    else $error("error alarm on a clean line");
  AST_FAILOVER_CAUSE: assert property (
    $rose(failover_o) |-> $past(out_of_service_i) || $past(carrier_alarm_i)
      || $past(out_of_service_i, 2) || $past(carrier_alarm_i, 2))
    else $error("failover without a trigger");
  AST_GROUP_CAUSE: assert property (
    $rose(group_fail_o) |-> $past(upstream_fail_i) || $past(link_fail_i)
      || $past(upstream_fail_i, 2) || $past(link_fail_i, 2))
    else $error("group fail without upstream fail");
  cover property (save_i);
  cover property (sig_slot_o);
  cover property (failover_o);
endmodule

// *** e1w_line_model.sv ***
`timescale 1ns/1ps
// Line and PCM bus side: one timeslot byte per strobe.
module e1w_line_model (
  input  wire logic       sys_clk_i,
  output logic            slot_strobe_o,
  output logic [4:0]      slot_num_o,
  output logic [7:0]      line_rx_o,
  output logic [7:0]      mate_rx_o,
  output logic [7:0]      pcm_tx_o,
  output logic            pcm_tx_valid_o
);
  initial begin
    slot_strobe_o = 1'b0;
    slot_num_o = 5'h00;
    line_rx_o = 8'hA5;
    mate_rx_o = 8'h5A;
    pcm_tx_o = 8'hC3;
    pcm_tx_valid_o = 1'b0;
  end
  task automatic send(input logic [4:0] n, input logic [7:0] rx,
                      input logic [7:0] mt, input logic [7:0] pc,
                      input logic v);
    @(posedge sys_clk_i);
    #1;
    slot_strobe_o = 1'b1;
    slot_num_o = n;
    line_rx_o = rx;
    mate_rx_o = mt;
    pcm_tx_o = pc;
    pcm_tx_valid_o = v;
    @(posedge sys_clk_i);
    #1;
    slot_strobe_o = 1'b0;
    pcm_tx_valid_o = 1'b0;
    // Released bytes are inverted so a stale value can never pass.
    line_rx_o = ~rx;
    mate_rx_o = ~mt;
    pcm_tx_o = ~pc;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import e1w_pkg::*;
;
  localparam logic [31:0] XC = CFG_RESET | 32'h0000_0001;
  localparam logic [31:0] TM = XC & ~32'h0000_0006;
  logic             sys_clk_i = 1'b0, reset_i = 1'b1;
  logic             stage_we_i = 1'b0, save_i = 1'b0, undo_i = 1'b0;
  logic [CFG_W-1:0] stage_data_i = '0;
  logic             slot_strobe_i, pcm_tx_valid_i;
  logic [4:0]       slot_num_i;
  logic [7:0]       line_rx_i, mate_rx_i, pcm_tx_i, mgmt_tx_i = 8'h01;
  logic             link_fail_i = 1'b0, mate_link_fail_i = 1'b0;
  logic [2:0]       upstream_fail_group_i = 3'h0, error_rate_exp_i = 3'h0;
  logic             upstream_fail_i = 1'b0, out_of_service_i = 1'b0;
  logic             carrier_alarm_i = 1'b0;
  logic [7:0]       line_tx_o, pcm_rx_o, mate_tx_o, mgmt_rx_o;
  logic             pcm_rx_valid_o, mgmt_rx_valid_o, mgmt_spare_bit_o;
  logic             crc4_enable_o, sig_slot_o, error_alarm_o;
  logic             failover_o, group_fail_o;
  logic [CFG_W-1:0] cfg_readback_o;
  logic [1:0]       port_state_o;
  logic [7:0]       codes [4] = '{8'h00, CODE_LLB, CODE_PLB, CODE_NLB};
  int               mismatches = 0, n_compared = 0;

  e1w_port i_dut (.*);
  e1w_line_model i_line (.sys_clk_i(sys_clk_i),
    .slot_strobe_o(slot_strobe_i), .slot_num_o(slot_num_i),
    .line_rx_o(line_rx_i), .mate_rx_o(mate_rx_i),
    .pcm_tx_o(pcm_tx_i), .pcm_tx_valid_o(pcm_tx_valid_i));

  always #10 sys_clk_i = ~sys_clk_i;

  // ======================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Stage a word, then save it or throw it away with undo.
  task automatic cfg(input logic [31:0] w, input logic drop);
    tick(1);
    stage_data_i = w;
    stage_we_i = 1'b1;
    tick(1);
    stage_we_i = 1'b0;
    save_i = ~drop;
    undo_i = drop;
    tick(1);
    save_i = 1'b0;
    undo_i = 1'b0;
    tick(3);
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ======================================
  // Sequence
  initial begin
    tick(8);
    reset_i = 1'b0;
    chk(cfg_readback_o, CFG_RESET);
    chk(port_state_o, E1W_STBY);
    chk(crc4_enable_o, 1'b1);
    i_line.send(5'h05, 8'h81, 8'h4B, 8'h3C, 1'b1);
    chk(line_tx_o, IDLE_BYTE);
    cfg(TM, 1'b1);
    chk(cfg_readback_o, CFG_RESET);
    chk(port_state_o, E1W_STBY);
    cfg(TM, 1'b0);
    chk(port_state_o, E1W_RUN);
    i_line.send(5'h05, 8'h81, 8'h4B, 8'h3C, 1'b1);
    chk(line_tx_o, 8'h3C);
    chk(mate_tx_o == 8'h81, 1'b0);
    cfg(TM | 32'h0000_0040, 1'b0);
    i_line.send(5'h05, 8'h81, 8'h4B, 8'h3C, 1'b1);
    chk(line_tx_o, 8'h3C ^ EVEN_MASK);
    cfg(XC, 1'b0);
    i_line.send(5'h07, 8'h96, 8'h4B, 8'h00, 1'b0);
    chk(mate_tx_o, 8'h96);
    chk(line_tx_o, 8'h4B);
    cfg(XC | 32'h0000_0100, 1'b0);
    i_line.send(5'h07, 8'h96, 8'h4B, 8'h00, 1'b0);
    chk(line_tx_o, 8'h96);
    chk(port_state_o, E1W_LOOP);
    cfg(XC | 32'h0000_0200, 1'b0);
    i_line.send(5'h07, 8'h96, 8'h4B, 8'h3C, 1'b1);
    chk(line_tx_o, AIS_BYTE);
    chk(pcm_rx_o, 8'h3C);
    cfg((XC & ~32'h0000_F800) | 32'h0000_1C00, 1'b0);
    i_line.send(5'h03, 8'h11, 8'h4B, 8'h5A, 1'b1);
    chk(pcm_rx_o, 8'h5A);
    chk(pcm_rx_valid_o, 1'b1);
    i_line.send(5'h04, 8'h11, 8'h4B, 8'h5A, 1'b1);
    chk(pcm_rx_o == 8'h5A, 1'b0);
    for (int g = 1; g < 4; g++) begin
      cfg(XC | (32'(g) << 16), 1'b0);
      i_line.send(5'h02, 8'h11, 8'h4B, 8'h3C, 1'b1);
      chk(line_tx_o, codes[g]);
    end
    cfg(XC | 32'h0000_0008, 1'b0);
    chk(crc4_enable_o, 1'b0);
    cfg(XC & ~32'h0000_0030, 1'b0);
    i_line.send(5'h10, 8'h11, 8'h4B, 8'h3C, 1'b1);
    chk(sig_slot_o, 1'b1);
    cfg(XC | 32'h0008_0000, 1'b0);
    i_line.send(5'h10, 8'h11, 8'h4B, 8'h3C, 1'b1);
    chk(sig_slot_o, 1'b0);
    i_line.send(5'h1F, 8'h6E, 8'h4B, 8'h3C, 1'b0);
    chk(mgmt_rx_valid_o, 1'b1);
    chk(mgmt_rx_o, 8'h6E);
    cfg(XC | 32'h0004_0000, 1'b0);
    mgmt_tx_i = 8'h00;
    i_line.send(5'h00, 8'h11, 8'h4B, 8'h3C, 1'b1);
    chk(mgmt_spare_bit_o, 1'b0);
    error_rate_exp_i = 3'h1;
    tick(3);
    chk(error_alarm_o, 1'b1);
    error_rate_exp_i = 3'h2;
    tick(3);
    chk(error_alarm_o, 1'b0);
    error_rate_exp_i = 3'h1;
    cfg(XC & ~32'h0070_0000, 1'b0);
    chk(error_alarm_o, 1'b0);
    error_rate_exp_i = 3'h0;
    cfg(XC | 32'h0080_0000, 1'b0);
    carrier_alarm_i = 1'b1;
    tick(3);
    chk(failover_o, 1'b0);
    out_of_service_i = 1'b1;
    tick(3);
    chk(failover_o, 1'b1);
    cfg(XC | 32'h0400_0000, 1'b0);
    upstream_fail_i = 1'b1;
    upstream_fail_group_i = 3'h3;
    tick(3);
    chk(group_fail_o, 1'b0);
    upstream_fail_group_i = 3'h2;
    tick(3);
    chk(group_fail_o, 1'b1);
    cfg(XC | 32'h0000_0080, 1'b0);
    mate_link_fail_i = 1'b1;
    i_line.send(5'h07, 8'h96, 8'h4B, 8'h3C, 1'b1);
    chk(line_tx_o, AIS_BYTE);
    mate_link_fail_i = 1'b0;
    link_fail_i = 1'b1;
    i_line.send(5'h07, 8'h96, 8'h4B, 8'h3C, 1'b1);
    chk(mate_tx_o, AIS_BYTE);
    chk(line_tx_o, 8'h3C);
    chk(group_fail_o, 1'b0);
    wrap_up();
  end
endmodule

bind e1w_port e1w_chk i_chk (.*);
